//--- hw/fchsp_port.sv
// Byte FIFO and the five-signal byte-paced host serial port
`timescale 1ns/1ps
`default_nettype none
`include "fchsp_map.svh"

//
// Overview of operation
// - Host data enters on the receive input, module data leaves on transmit output.
// - With a packet ready, send-request goes low until host clear-to-send or timeout.
// - On timeout release send-request, wait at most 500 ms, then retry same packet.
// - Send-request is negated within 10 ms of seeing host clear-to-send low.
// - Next byte waits until host clear-to-send is seen reasserted.
// - Start bit begins within 10 ms of seeing host clear-to-send asserted.
// - Module clear-to-send stays high until and unless the network is joined.
// - Module clear-to-send goes high when no buffer space remains.
// - Local packets are received any time, whatever module clear-to-send shows.
// - Active-low trigger input asks for a timestamp packet.
// - Host rate within 2 percent, module rate within 1 percent.
// - Module answers every host request within 125 ms.
// - At least 20 ms between packets from either sender.
// - Link runs at 9600 bits per second both ways.

// Synchronous FIFO with registered full and empty flags
module fchsp_fifo #(
    parameter int WIDTH = `FCHSP_FIFO_WIDTH,
    parameter int DEPTH = `FCHSP_FIFO_DEPTH
) (
    input  wire logic             ref_clk_i,
    input  wire logic             resetn_i,
    input  wire logic             clk_en_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             ready_ff;
    logic             valid_ff;
    logic [AW-1:0]    nxt_wr_ptr;
    logic [AW-1:0]    nxt_rd_ptr;
    logic [AW:0]      nxt_count;
    logic             push;
    logic             pop;

    assign push        = in_valid_i & ready_ff;
    assign pop         = out_ready_i & valid_ff;
    assign in_ready_o  = ready_ff;
    assign out_valid_o = valid_ff;
    assign out_data_o  = mem[rd_ptr_ff];

    // Pointer and level update; flags come from the next level
    always_comb begin
        nxt_wr_ptr = push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
        nxt_rd_ptr = pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
        nxt_count  = count_ff;
        if (push && !pop) begin
            nxt_count = (AW+1)'(count_ff + 1'b1);
        end else if (pop && !push) begin
            nxt_count = (AW+1)'(count_ff - 1'b1);
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
            ready_ff  <= 1'b1;
            valid_ff  <= 1'b0;
        end else if (clk_en_i) begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff  <= nxt_count;
            ready_ff  <= (nxt_count != (AW+1)'(DEPTH));
            valid_ff  <= (nxt_count != '0);
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge ref_clk_i) begin
        if (clk_en_i && push) begin
            mem[wr_ptr_ff] <= in_data_i;
        end
    end
endmodule

// Device end of the host serial port
module fchsp_port #(
    parameter int REQ_TIMEOUT_CYC = `FCHSP_REQ_TIMEOUT_CYC,
    parameter int RETRY_WAIT_CYC  = `FCHSP_RETRY_WAIT_CYC,
    parameter int GAP_CYC         = `FCHSP_GAP_CYC,
    parameter int FIFO_DEPTH      = `FCHSP_FIFO_DEPTH
) (
    input  wire logic       ref_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       clk_en_i,
    input  wire logic       uart_rx_i,
    output logic            uart_tx_o,
    output logic            module_send_request_n_o,
    input  wire logic       host_clear_to_send_n_i,
    output logic            module_clear_to_send_n_o,
    input  wire logic       timestamp_trigger_n_i,
    input  wire logic       network_joined_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_last_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    input  wire logic       rx_ready_i,
    output logic            timestamp_req_o
);
    localparam int TW = `FCHSP_TIMER_W;
    localparam logic [11:0] BIT_LAST  = 12'(`FCHSP_BIT_CYC - 1);
    localparam logic [11:0] HALF_LAST = 12'(`FCHSP_HALF_BIT_CYC - 1);
    localparam logic [TW-1:0] TO_LAST  = TW'(REQ_TIMEOUT_CYC - 1);
    localparam logic [TW-1:0] RW_LAST  = TW'(RETRY_WAIT_CYC - 1);
    localparam logic [TW-1:0] GAP_LAST = TW'(GAP_CYC - 1);

    // Pin synchronisers: bit 0 data in, bit 1 host clear-to-send, bit 2 trigger
    logic [2:0] pin_in;
    logic [2:0] filt_ff;
    assign pin_in = {timestamp_trigger_n_i, host_clear_to_send_n_i, uart_rx_i};

    for (genvar g = 0; g < 3; g++) begin : g_sync
        logic [`FCHSP_SYNC_STAGES-1:0] sync_ff;
        logic                          nxt_filt;
        // A change counts only once the last two stages agree
        always_comb begin
            nxt_filt = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : filt_ff[g];
        end
        always_ff @(posedge ref_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                sync_ff    <= '1;
                filt_ff[g] <= 1'b1;
            end else if (clk_en_i) begin
                sync_ff    <= {sync_ff[1:0], pin_in[g]};
                filt_ff[g] <= nxt_filt;
            end
        end
    end

    logic rx_line;
    logic cts_low;
    logic trig_line;
    assign rx_line   = filt_ff[0];
    assign cts_low   = ~filt_ff[1];
    assign trig_line = filt_ff[2];

    // Outbound packets are queued here; a full queue stalls the user
    logic [8:0] q_data;
    logic       q_valid;
    logic       q_pop;

    fchsp_fifo #(
        .WIDTH (`FCHSP_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .ref_clk_i   (ref_clk_i),
        .resetn_i    (resetn_i),
        .clk_en_i    (clk_en_i),
        .in_data_i   ({tx_last_i, tx_data_i}),
        .in_valid_i  (tx_valid_i),
        .in_ready_o  (tx_ready_o),
        .out_data_o  (q_data),
        .out_valid_o (q_valid),
        .out_ready_i (q_pop)
    );

    // Transmit state
    fchsp_pkg::fchsp_tx_state_type tx_st_ff, nxt_tx_st;
    logic [TW-1:0] tmr_ff, nxt_tmr;
    logic [11:0]   tbit_ff, nxt_tbit;
    logic [3:0]    tidx_ff, nxt_tidx;
    logic [8:0]    tsh_ff, nxt_tsh;
    logic          tlast_ff, nxt_tlast;
    logic          saw_high_ff, nxt_saw_high;
    logic          tx_ff, nxt_tx;
    logic          rts_n_ff, nxt_rts_n;
    logic          start_byte;

    // Transmit sequencing: request, pace each byte, then hold the packet gap
    always_comb begin
        nxt_tx_st    = tx_st_ff;
        nxt_tmr      = tmr_ff;
        nxt_tbit     = tbit_ff;
        nxt_tidx     = tidx_ff;
        nxt_tsh      = tsh_ff;
        nxt_tlast    = tlast_ff;
        nxt_saw_high = saw_high_ff | ~cts_low;
        nxt_tx       = tx_ff;
        nxt_rts_n    = rts_n_ff;
        start_byte   = 1'b0;
        q_pop        = 1'b0;
        case (tx_st_ff)
            fchsp_pkg::TX_IDLE: begin
                nxt_tx = 1'b1;
                if (q_valid) begin
                    nxt_tx_st = fchsp_pkg::TX_REQ;
                    nxt_tmr   = '0;
                    nxt_rts_n = 1'b0;
                end
            end
            fchsp_pkg::TX_REQ: begin
                if (cts_low) begin
                    nxt_rts_n  = 1'b1;
                    start_byte = 1'b1;
                end else if (tmr_ff == TO_LAST) begin
                    nxt_rts_n = 1'b1;
                    nxt_tx_st = fchsp_pkg::TX_RETRY;
                    nxt_tmr   = '0;
                end else begin
                    nxt_tmr = TW'(tmr_ff + 1'b1);
                end
            end
            fchsp_pkg::TX_RETRY: begin
                if (tmr_ff == RW_LAST) begin
                    nxt_rts_n = 1'b0;
                    nxt_tx_st = fchsp_pkg::TX_REQ;
                    nxt_tmr   = '0;
                end else begin
                    nxt_tmr = TW'(tmr_ff + 1'b1);
                end
            end
            fchsp_pkg::TX_SEND: begin
                if (tbit_ff != BIT_LAST) begin
                    nxt_tbit = 12'(tbit_ff + 1'b1);
                end else if (tidx_ff == 4'(`FCHSP_STOP_IDX)) begin
                    // Stop bit has run its full period
                    nxt_tx_st = tlast_ff ? fchsp_pkg::TX_GAP : fchsp_pkg::TX_ACK;
                    nxt_tmr   = '0;
                end else begin
                    nxt_tbit = '0;
                    nxt_tx   = tsh_ff[0];
                    nxt_tsh  = {1'b1, tsh_ff[8:1]};
                    nxt_tidx = 4'(tidx_ff + 1'b1);
                end
            end
            fchsp_pkg::TX_ACK: begin
                // Only a high-then-low cycle of the host line releases the next byte
                if (saw_high_ff && cts_low && q_valid) begin
                    start_byte = 1'b1;
                end
            end
            fchsp_pkg::TX_GAP: begin
                if (tmr_ff == GAP_LAST) begin
                    nxt_tx_st = fchsp_pkg::TX_IDLE;
                end else begin
                    nxt_tmr = TW'(tmr_ff + 1'b1);
                end
            end
            default: nxt_tx_st = fchsp_pkg::TX_IDLE;
        endcase
        if (start_byte) begin
            q_pop        = 1'b1;
            nxt_tx_st    = fchsp_pkg::TX_SEND;
            nxt_tx       = 1'b0;
            nxt_tsh      = {1'b1, q_data[7:0]};
            nxt_tlast    = q_data[8];
            nxt_tbit     = '0;
            nxt_tidx     = '0;
            nxt_saw_high = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_st_ff    <= fchsp_pkg::TX_IDLE;
            tmr_ff      <= '0;
            tbit_ff     <= '0;
            tidx_ff     <= '0;
            tsh_ff      <= '1;
            tlast_ff    <= 1'b0;
            saw_high_ff <= 1'b0;
            tx_ff       <= 1'b1;
            rts_n_ff    <= 1'b1;
        end else if (clk_en_i) begin
            tx_st_ff    <= nxt_tx_st;
            tmr_ff      <= nxt_tmr;
            tbit_ff     <= nxt_tbit;
            tidx_ff     <= nxt_tidx;
            tsh_ff      <= nxt_tsh;
            tlast_ff    <= nxt_tlast;
            saw_high_ff <= nxt_saw_high;
            tx_ff       <= nxt_tx;
            rts_n_ff    <= nxt_rts_n;
        end
    end

    assign uart_tx_o               = tx_ff;
    assign module_send_request_n_o = rts_n_ff;

    // Receive state
    fchsp_pkg::fchsp_rx_state_type rx_st_ff, nxt_rx_st;
    logic [11:0] rbit_ff, nxt_rbit;
    logic [2:0]  ridx_ff, nxt_ridx;
    logic [7:0]  rsh_ff, nxt_rsh;
    logic [7:0]  rdata_ff, nxt_rdata;
    logic        rvalid_ff, nxt_rvalid;
    logic        mcts_n_ff, nxt_mcts_n;
    logic        trig_d_ff;
    logic        ts_ff, nxt_ts;

    // Mid-bit sampling receiver; every frame with a high stop bit is taken, whatever the module clear-to-send
    always_comb begin
        nxt_rx_st = rx_st_ff;
        nxt_rbit  = 12'(rbit_ff + 1'b1);
        nxt_ridx  = ridx_ff;
        nxt_rsh   = rsh_ff;
        nxt_rdata = rdata_ff;
        // A new byte wins over a take in the same cycle
        nxt_rvalid = rvalid_ff & ~rx_ready_i;
        case (rx_st_ff)
            fchsp_pkg::RX_IDLE: begin
                nxt_rbit = '0;
                if (!rx_line) begin
                    nxt_rx_st = fchsp_pkg::RX_START;
                end
            end
            fchsp_pkg::RX_START: begin
                if (rbit_ff == HALF_LAST) begin
                    nxt_rbit  = '0;
                    nxt_ridx  = '0;
                    nxt_rx_st = rx_line ? fchsp_pkg::RX_IDLE : fchsp_pkg::RX_DATA;
                end
            end
            fchsp_pkg::RX_DATA: begin
                if (rbit_ff == BIT_LAST) begin
                    nxt_rbit = '0;
                    nxt_rsh  = {rx_line, rsh_ff[7:1]};
                    nxt_ridx = 3'(ridx_ff + 1'b1);
                    if (ridx_ff == 3'(`FCHSP_DATA_BITS - 1)) begin
                        nxt_rx_st = fchsp_pkg::RX_STOP;
                    end
                end
            end
            fchsp_pkg::RX_STOP: begin
                if (rbit_ff == BIT_LAST) begin
                    nxt_rx_st = fchsp_pkg::RX_IDLE;
                    // Framing errors are dropped silently
                    if (rx_line) begin
                        nxt_rdata  = rsh_ff;
                        nxt_rvalid = 1'b1;
                    end
                end
            end
            default: nxt_rx_st = fchsp_pkg::RX_IDLE;
        endcase
        // Only one byte of room: a held byte means no space for another packet
        nxt_mcts_n = ~network_joined_i | nxt_rvalid;
        nxt_ts     = trig_d_ff & ~trig_line;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_st_ff  <= fchsp_pkg::RX_IDLE;
            rbit_ff   <= '0;
            ridx_ff   <= '0;
            rsh_ff    <= '0;
            rdata_ff  <= '0;
            rvalid_ff <= 1'b0;
            mcts_n_ff <= 1'b1;
            trig_d_ff <= 1'b1;
            ts_ff     <= 1'b0;
        end else if (clk_en_i) begin
            rx_st_ff  <= nxt_rx_st;
            rbit_ff   <= nxt_rbit;
            ridx_ff   <= nxt_ridx;
            rsh_ff    <= nxt_rsh;
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            mcts_n_ff <= nxt_mcts_n;
            trig_d_ff <= trig_line;
            ts_ff     <= nxt_ts;
        end
    end

    assign rx_data_o                = rdata_ff;
    assign rx_valid_o               = rvalid_ff;
    assign module_clear_to_send_n_o = mcts_n_ff;
    assign timestamp_req_o          = ts_ff;

    // Checks; clock enable held high is assumed while they are judged
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i || !clk_en_i);

    property p_rts_release;
        (tx_st_ff == fchsp_pkg::TX_REQ) && cts_low |=> module_send_request_n_o && !uart_tx_o;
    endproperty
    a_rts_release: assert property (p_rts_release) else $error("Send-request not released");

    property p_rts_timeout;
        (tx_st_ff == fchsp_pkg::TX_REQ) && !cts_low && (tmr_ff == TO_LAST)
            |=> module_send_request_n_o && (tx_st_ff == fchsp_pkg::TX_RETRY);
    endproperty
    a_rts_timeout: assert property (p_rts_timeout) else $error("Request timeout missed");

    property p_rts_held;
        (tx_st_ff == fchsp_pkg::TX_REQ) && !cts_low && (tmr_ff != TO_LAST)
            |=> !module_send_request_n_o;
    endproperty
    a_rts_held: assert property (p_rts_held) else $error("Send-request dropped early");

    property p_not_joined;
        !network_joined_i |=> module_clear_to_send_n_o;
    endproperty
    a_not_joined: assert property (p_not_joined) else $error("Clear-to-send low off network");

    property p_no_space;
        rx_valid_o && !rx_ready_i |=> module_clear_to_send_n_o;
    endproperty
    a_no_space: assert property (p_no_space) else $error("Clear-to-send low while full");

    property p_paced_start;
        (tx_st_ff == fchsp_pkg::TX_ACK) && saw_high_ff && cts_low && q_valid
            |=> !uart_tx_o ##1 !uart_tx_o;
    endproperty
    a_paced_start: assert property (p_paced_start) else $error("Byte not started");

    property p_stop_bit;
        (tx_st_ff == fchsp_pkg::TX_SEND) && (tidx_ff == 4'(`FCHSP_STOP_IDX)) |-> uart_tx_o;
    endproperty
    a_stop_bit: assert property (p_stop_bit) else $error("Stop bit not high");

    property p_gap_quiet;
        (tx_st_ff == fchsp_pkg::TX_GAP) |-> module_send_request_n_o && uart_tx_o;
    endproperty
    a_gap_quiet: assert property (p_gap_quiet) else $error("Activity inside packet gap");

    property p_trigger;
        $fell(trig_line) |=> timestamp_req_o ##1 !timestamp_req_o;
    endproperty
    a_trigger: assert property (p_trigger) else $error("Timestamp request missing");
endmodule
`default_nettype wire

//--- shared/fchsp_map.svh
// Timing, framing and buffer constants of the flow-controlled host serial port
`ifndef FCHSP_MAP_SVH
`define FCHSP_MAP_SVH

`define FCHSP_CLK_HZ            20000000
`define FCHSP_BAUD              9600
`define FCHSP_BIT_CYC           (`FCHSP_CLK_HZ / `FCHSP_BAUD)
`define FCHSP_HALF_BIT_CYC      (`FCHSP_BIT_CYC / 2)
`define FCHSP_DATA_BITS         8
`define FCHSP_STOP_IDX          9
`define FCHSP_CYC_PER_MS        (`FCHSP_CLK_HZ / 1000)
`define FCHSP_REQ_TIMEOUT_MS    500
`define FCHSP_REQ_TIMEOUT_CYC   (`FCHSP_REQ_TIMEOUT_MS * `FCHSP_CYC_PER_MS)
`define FCHSP_RETRY_WAIT_MS     500
`define FCHSP_RETRY_WAIT_CYC    (`FCHSP_RETRY_WAIT_MS * `FCHSP_CYC_PER_MS)
`define FCHSP_GAP_MS            20
`define FCHSP_GAP_CYC           (`FCHSP_GAP_MS * `FCHSP_CYC_PER_MS)
`define FCHSP_FIFO_DEPTH        16
`define FCHSP_FIFO_WIDTH        9
`define FCHSP_SYNC_STAGES       3
`define FCHSP_TIMER_W           24

`endif

//--- shared/fchsp_pkg.sv
// State types of the flow-controlled host serial port
`default_nettype none
package fchsp_pkg;
    typedef enum logic [2:0] {
        TX_IDLE,
        TX_REQ,
        TX_RETRY,
        TX_SEND,
        TX_ACK,
        TX_GAP
    } fchsp_tx_state_type;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } fchsp_rx_state_type;
endpackage
`default_nettype wire

//--- testbench/fchsp_host_model.sv
// Behavioural host microcontroller on the byte-paced serial lines
`timescale 1ns/1ps
`default_nettype none
module fchsp_host_model #(
    parameter int BIT_CYC   = 2083,
    parameter int CTS_DELAY = 400
) (
    input  wire logic       clk_i,
    input  wire logic       uart_tx_i,
    input  wire logic       send_request_n_i,
    output logic            host_clear_to_send_n_o,
    output logic [8:0]      got_o,
    output logic            got_valid_o
);
    int i;
    // Answers the first request late so the module has to time out and retry;
    // CTS_DELAY of zero gives a prompt host
    initial begin
        host_clear_to_send_n_o = 1'b1;
        got_o = 9'h000;
        got_valid_o = 1'b0;
        wait (send_request_n_i === 1'b0);
        repeat (CTS_DELAY) @(posedge clk_i);
        host_clear_to_send_n_o <= 1'b0;
        forever begin
            @(posedge clk_i);
            if (uart_tx_i === 1'b0) begin
                repeat (BIT_CYC / 2) @(posedge clk_i);
                for (i = 0; i < 9; i++) begin
                    repeat (BIT_CYC) @(posedge clk_i);
                    got_o[i] <= uart_tx_i;
                end
                got_valid_o <= 1'b1;
                // Pacing pulse of 1 us, sent well after the start bit
                host_clear_to_send_n_o <= 1'b1;
                @(posedge clk_i);
                got_valid_o <= 1'b0;
                repeat (19) @(posedge clk_i);
                host_clear_to_send_n_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/fchsp_port_test.sv
// Self-checking bench of the flow-controlled host serial port
`timescale 1ns/1ps
`default_nettype none
module fchsp_port_test;
    localparam int BIT_CYC = 2083;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        clk_en = 1'b1;
    logic        uart_rx = 1'b1;
    logic        uart_tx;
    logic        rts_n;
    logic        cts_n;
    logic        mcts_n;
    logic        trig_n = 1'b1;
    logic        joined = 1'b0;
    logic [7:0]  tx_data = 8'h00;
    logic        tx_last = 1'b0;
    logic        tx_valid = 1'b0;
    logic        tx_ready;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        rx_ready = 1'b0;
    logic        ts_req;
    logic [8:0]  got;
    logic        got_valid;
    logic        rts_q = 1'b1;
    logic [31:0] lfsr = 32'hac74;
    logic [7:0]  vals[6];
    logic [7:0]  exp_tx[$];
    logic [7:0]  exp_rx[$];
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          n_cycles = 0;
    int          n_ts = 0;
    int          n_retry = 0;
    int          n_refused = 0;
    int          k;

    // Depth 2 so the buffer refuses within a short run; short timeouts too
    fchsp_port #(.REQ_TIMEOUT_CYC(200), .RETRY_WAIT_CYC(100), .GAP_CYC(50),
                 .FIFO_DEPTH(2)) uut (
        .ref_clk_i(clk), .resetn_i(resetn), .clk_en_i(clk_en),
        .uart_rx_i(uart_rx), .uart_tx_o(uart_tx), .module_send_request_n_o(rts_n),
        .host_clear_to_send_n_i(cts_n), .module_clear_to_send_n_o(mcts_n),
        .timestamp_trigger_n_i(trig_n), .network_joined_i(joined),
        .tx_data_i(tx_data), .tx_last_i(tx_last), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
        .rx_ready_i(rx_ready), .timestamp_req_o(ts_req));

    fchsp_host_model #(.BIT_CYC(BIT_CYC), .CTS_DELAY(400)) host (
        .clk_i(clk), .uart_tx_i(uart_tx), .send_request_n_i(rts_n),
        .host_clear_to_send_n_o(cts_n), .got_o(got), .got_valid_o(got_valid));

    always #25 clk = ~clk;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic cmp_bit(input string what, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Valid stays up between words; each push drives it high and the caller drops it after the last
    task automatic push_byte(input logic [7:0] d, input logic last);
        int w;
        tx_data <= d;
        tx_last <= last;
        tx_valid <= 1'b1;
        exp_tx.push_back(d);
        @(posedge clk);
        for (w = 0; w < 50000 && tx_ready !== 1'b1; w++) begin
            n_refused++;
            @(posedge clk);
        end
    endtask

    task automatic send_rx(input logic [7:0] d);
        int i;
        logic [9:0] fr;
        fr = {1'b1, d, 1'b0};
        // A network-bound packet only starts once the module shows room
        while (mcts_n !== 1'b0) begin
            @(posedge clk);
        end
        exp_rx.push_back(d);
        for (i = 0; i < 10; i++) begin
            uart_rx <= fr[i];
            repeat (BIT_CYC) @(posedge clk);
        end
    endtask

    // Watcher: pairs each result with the oldest note and guards against hangs;
    // three paced bytes take about 63,000 cycles, so the ceiling leaves margin
    always @(posedge clk) begin
        n_cycles++;
        rts_q <= rts_n;
        if (rts_n === 1'b1 && rts_q === 1'b0 && cts_n === 1'b1) n_retry++;
        if (ts_req === 1'b1) n_ts++;
        if (got_valid === 1'b1) begin
            cmp_bit("stop bit", 1'b1, got[8]);
            cmp_byte("host byte", exp_tx.size() ? exp_tx.pop_front() : 8'hxx, got[7:0]);
        end
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            cmp_byte("rx byte", exp_rx.size() ? exp_rx.pop_front() : 8'hxx, rx_data);
        end
        if (n_cycles > 90000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        for (k = 0; k < 6; k++) begin
            lfsr = lfsr_next(lfsr);
            vals[k] = lfsr[7:0];
        end
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        cmp_bit("mcts before join", 1'b1, mcts_n);
        // Enable low freezes every flop, so neither the join nor the trigger shows yet
        clk_en <= 1'b0;
        joined <= 1'b1;
        trig_n <= 1'b0;
        repeat (4) @(posedge clk);
        cmp_bit("mcts frozen", 1'b1, mcts_n);
        cmp_bit("timestamp frozen", 1'b0, ts_req);
        clk_en <= 1'b1;
        repeat (8) @(posedge clk);
        cmp_bit("mcts after join", 1'b0, mcts_n);
        trig_n <= 1'b1;
        fork
            begin
                // Host is slow, so the small buffer has to refuse
                for (k = 0; k < 3; k++) push_byte(vals[k], k == 2);
                tx_valid <= 1'b0;
            end
            begin
                send_rx(vals[3]);
                cmp_bit("mcts while byte held", 1'b1, mcts_n);
                rx_ready <= 1'b1;
                repeat (8) @(posedge clk);
                cmp_bit("mcts after take", 1'b0, mcts_n);
                send_rx(vals[4]);
                send_rx(vals[5]);
            end
        join
        for (k = 0; k < 60000 && exp_tx.size() + exp_rx.size() != 0; k++) @(posedge clk);
        repeat (200) @(posedge clk);
        cmp_bit("all bytes seen", 1'b1, exp_tx.size() + exp_rx.size() == 0);
        cmp_bit("buffer refused", 1'b1, n_refused > 0);
        cmp_bit("request retried", 1'b1, n_retry > 0);
        cmp_bit("one timestamp pulse", 1'b1, n_ts == 1);
        final_report();
    end
endmodule
`default_nettype wire
